// [hw/fpec_top.sv]
// nvm program/erase sequencer with apb registers, key lock and array
// assumes core move-writes and debug requests are on pclk, supply bits are async
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - programming only clears bits; ones come back only through erase
// - erase fills one whole 512-byte page with 0xff
// - program and erase are timed by internal counters
// - core is stalled while an operation runs
// - write-enable steers move-writes into the nvm array
// - write-enable holds across operations until software clears it
// - key register takes 0xa5 then 0xf1 before each core move-write operation
// - no timing limit between the two key writes
// - wrong or misordered key blocks operations until reset
// - attempt before full key sequence also blocks until reset
// - lock re-engages as every core move-write operation starts; fresh keys needed
// - attempt with supply monitor or its reset off raises error reset
// - erase-enable plus write-enable plus keys: one write erases page
// - write-enable, erase-enable clear plus keys: one write programs byte
// - short-address move-writes never reach above 0x00ff in the nvm array; data ram stores take the full address
// - debug port can program and erase without keys
// - error-caused reset leaves the error flag set afterwards
module fpec_top #(
	parameter int unsigned ADDR_W       = 14,
	parameter int unsigned PROG_CYCLES  = fpec_pkg::PROG_CYC,
	parameter int unsigned ERASE_CYCLES = fpec_pkg::ERASE_CYC
) (
	// clock and resets
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   por_n,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// core move-write and code read
	input  wire fpec_pkg::fpec_move_req_t move_req,
	input  wire logic [ADDR_W-1:0]      code_addr,
	output logic      [7:0]             code_data,
	output logic                        core_stall,
	// data ram store path
	output logic                        ram_wr_valid,
	output logic      [15:0]            ram_wr_addr,
	output logic      [7:0]             ram_wr_data,
	// two-wire debug port programming
	input  wire fpec_pkg::fpec_dbg_req_t dbg_req,
	// supply monitor (async) and error reset request
	input  wire logic                   vmon_enable,
	input  wire logic                   vmon_reset_enable,
	output logic                        nvm_error_device_reset
);
	// ==========================================================
	// state
	logic [7:0]                 mem [2**ADDR_W];
	logic [1:0]                 control_reg;
	fpec_pkg::fpec_key_state_t  key_reg, key_next;
	logic                       busy_reg, erase_reg, err_flag_reg, err_rst_reg;
	logic [ADDR_W-1:0]          op_addr_reg;
	logic [7:0]                 op_data_reg;
	logic [31:0]                cnt_reg;
	logic [1:0]                 vm_sync_reg, vr_sync_reg;
	logic [31:0]                prdata_reg;
	logic                       pready_reg, pslverr_reg;
	logic                       ram_v_reg;
	logic [15:0]                ram_a_reg;
	logic [7:0]                 ram_d_reg, code_reg;

	logic        store_write_enable, store_erase_enable, supply_ok;
	logic        apb_done, apb_wr, ctrl_wr, key_wr, rst_wr, mapped;
	logic        attempt, cpu_go, dbg_go, op_done;
	logic [15:0] eff_addr;
	logic [31:0] limit;

	assign store_write_enable = control_reg[fpec_pkg::WE_BIT];
	assign store_erase_enable = control_reg[fpec_pkg::EE_BIT];
	assign supply_ok = vm_sync_reg[1] & vr_sync_reg[1];

	// ==========================================================
	// supply monitor synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vm_sync_reg <= 2'h0;
			vr_sync_reg <= 2'h0;
		end else begin
			vm_sync_reg <= {vm_sync_reg[0], vmon_enable};
			vr_sync_reg <= {vr_sync_reg[0], vmon_reset_enable};
		end
	end

	// ==========================================================
	// apb slave: one wait state, registered answer
	assign apb_done = psel & penable & pready_reg;
	assign apb_wr   = apb_done & pwrite;
	assign ctrl_wr  = apb_wr & (paddr == fpec_pkg::OFS_CONTROL);
	assign key_wr   = apb_wr & (paddr == fpec_pkg::OFS_KEY);
	assign rst_wr   = apb_wr & (paddr == fpec_pkg::OFS_RESET_SOURCE);
	assign mapped   = (paddr == fpec_pkg::OFS_CONTROL) | (paddr == fpec_pkg::OFS_KEY) |
	                  (paddr == fpec_pkg::OFS_STATUS) | (paddr == fpec_pkg::OFS_RESET_SOURCE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
			prdata_reg  <= 32'h0;
			if (psel && penable && !pready_reg && !pwrite) begin
				case (paddr)
					fpec_pkg::OFS_CONTROL: prdata_reg <= {30'h0, control_reg};
					fpec_pkg::OFS_KEY:     prdata_reg <= {30'h0, key_reg};
					fpec_pkg::OFS_STATUS:  prdata_reg <= {27'h0, supply_ok, erase_reg,
					                                      busy_reg, key_reg};
					fpec_pkg::OFS_RESET_SOURCE: prdata_reg <= {31'h0, err_flag_reg};
					default:               prdata_reg <= 32'h0;
				endcase
			end
		end
	end
	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// enables stay until software rewrites them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= fpec_pkg::CONTROL_RST;
		end else if (ctrl_wr) begin
			control_reg <= pwdata[1:0];
		end
	end

	// ==========================================================
	// key checker
	assign attempt  = move_req.valid & store_write_enable & ~busy_reg;
	assign cpu_go   = attempt & supply_ok & (key_reg == fpec_pkg::KS_ARMED);
	assign dbg_go   = dbg_req.valid & ~busy_reg & ~attempt;
	assign eff_addr = move_req.short_addr ? {8'h00, move_req.addr[7:0]} : move_req.addr;

	always_comb begin
		key_next = key_reg;
		if (key_reg == fpec_pkg::KS_BLOCKED) begin
			key_next = fpec_pkg::KS_BLOCKED;
		end else if (attempt && supply_ok) begin
			// armed goes back to locked in the cycle one operation starts
			key_next = (key_reg == fpec_pkg::KS_ARMED) ? fpec_pkg::KS_LOCKED
			                                           : fpec_pkg::KS_BLOCKED;
		end else if (key_wr) begin
			// only order and value matter, never spacing
			case (key_reg)
				fpec_pkg::KS_LOCKED: key_next = (pwdata[7:0] == fpec_pkg::KEY_FIRST) ?
				                                fpec_pkg::KS_FIRST : fpec_pkg::KS_BLOCKED;
				fpec_pkg::KS_FIRST:  key_next = (pwdata[7:0] == fpec_pkg::KEY_SECOND) ?
				                                fpec_pkg::KS_ARMED : fpec_pkg::KS_BLOCKED;
				default:             key_next = fpec_pkg::KS_BLOCKED;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_reg <= fpec_pkg::KS_LOCKED;
		end else begin
			key_reg <= key_next;
		end
	end

	// ==========================================================
	// supply check: an attempt without a guarded supply asks for reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_rst_reg <= 1'b0;
		end else begin
			err_rst_reg <= attempt & ~supply_ok;
		end
	end
	assign nvm_error_device_reset = err_rst_reg;

	// flag lives on power-on reset so it survives the reset it caused
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			err_flag_reg <= 1'b0;
		end else if (err_rst_reg) begin
			err_flag_reg <= 1'b1;
		end else if (rst_wr && pwdata[fpec_pkg::ERRFLAG_BIT]) begin
			err_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// operation timer
	assign limit   = erase_reg ? ERASE_CYCLES - 32'd1 : PROG_CYCLES - 32'd1;
	assign op_done = busy_reg & (cnt_reg == limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg    <= 1'b0;
			erase_reg   <= 1'b0;
			cnt_reg     <= 32'h0;
			op_addr_reg <= '0;
			op_data_reg <= 8'h0;
		end else if (cpu_go || dbg_go) begin
			busy_reg    <= 1'b1;
			erase_reg   <= cpu_go ? store_erase_enable : dbg_req.erase;
			cnt_reg     <= 32'h0;
			op_addr_reg <= cpu_go ? eff_addr[ADDR_W-1:0] : dbg_req.addr[ADDR_W-1:0];
			op_data_reg <= cpu_go ? move_req.data : dbg_req.data;
		end else if (op_done) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg + 32'd1;
		end
	end
	assign core_stall = busy_reg;

	// ==========================================================
	// array: erase sweeps one byte a cycle, program ands in at the end
	always_ff @(posedge pclk) begin
		if (busy_reg && erase_reg && cnt_reg < 32'(fpec_pkg::PAGE_BYTES)) begin
			mem[{op_addr_reg[ADDR_W-1:fpec_pkg::PAGE_W],
			     cnt_reg[fpec_pkg::PAGE_W-1:0]}] <= fpec_pkg::ERASED;
		end else if (op_done && !erase_reg) begin
			mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
		end
		code_reg <= mem[code_addr];
	end
	assign code_data = code_reg;

	// ordinary stores pass to data ram
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_v_reg <= 1'b0;
			ram_a_reg <= 16'h0;
			ram_d_reg <= 8'h0;
		end else begin
			ram_v_reg <= move_req.valid & ~store_write_enable & ~busy_reg;
			ram_a_reg <= move_req.addr;
			ram_d_reg <= move_req.data;
		end
	end
	assign ram_wr_valid = ram_v_reg;
	assign ram_wr_addr  = ram_a_reg;
	assign ram_wr_data  = ram_d_reg;

	// ==========================================================
	// checks
	a_blocked_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		key_reg == fpec_pkg::KS_BLOCKED |=> key_reg == fpec_pkg::KS_BLOCKED)
		else $error("blocked state left without reset");
	a_early_attempt: assert property (@(posedge pclk) disable iff (!presetn)
		attempt && supply_ok && key_reg != fpec_pkg::KS_ARMED
		|=> key_reg == fpec_pkg::KS_BLOCKED && !busy_reg)
		else $error("unkeyed attempt did not block");
	a_key_order: assert property (@(posedge pclk) disable iff (!presetn)
		key_wr && !attempt && key_reg == fpec_pkg::KS_FIRST && pwdata[7:0] == fpec_pkg::KEY_SECOND
		|=> key_reg == fpec_pkg::KS_ARMED)
		else $error("second key did not arm");
	a_relock_after: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_go |=> busy_reg && key_reg == fpec_pkg::KS_LOCKED)
		else $error("lock not restored after start");
	a_supply_error: assert property (@(posedge pclk) disable iff (!presetn)
		attempt && !supply_ok |=> nvm_error_device_reset && !busy_reg)
		else $error("bad supply attempt not flagged");
	a_we_holds: assert property (@(posedge pclk) disable iff (!presetn)
		busy_reg && !ctrl_wr |=> store_write_enable == $past(store_write_enable))
		else $error("write enable changed by operation");
	a_stall_length: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(busy_reg) && !erase_reg |-> core_stall [*2])
		else $error("stall dropped early");
	a_short_range: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_go && move_req.short_addr |=> op_addr_reg[ADDR_W-1:8] == '0)
		else $error("short address reached high memory");
	a_ram_route: assert property (@(posedge pclk) disable iff (!presetn)
		move_req.valid && !store_write_enable && !busy_reg && !dbg_req.valid
		|=> ram_wr_valid && !busy_reg)
		else $error("plain store not routed to ram");
	a_time_done: assert property (@(posedge pclk) disable iff (!presetn)
		op_done |=> !busy_reg && !core_stall)
		else $error("operation did not end at limit");
	a_nvm_not_ram: assert property (@(posedge pclk) disable iff (!presetn)
		move_req.valid && store_write_enable |=> !ram_wr_valid)
		else $error("enabled move-write leaked to data ram");
	a_first_waits: assert property (@(posedge pclk) disable iff (!presetn)
		key_reg == fpec_pkg::KS_FIRST && !key_wr && !attempt
		|=> key_reg == fpec_pkg::KS_FIRST)
		else $error("first key lost while waiting");
	a_debug_keyless: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_go && !key_wr |=> busy_reg && key_reg == $past(key_reg))
		else $error("debug request did not start cleanly");
	// a byte may only lose ones when programmed
	a_program_clears: assert property (@(posedge pclk) disable iff (!presetn)
		op_done && !erase_reg |=> (mem[op_addr_reg] & ~$past(mem[op_addr_reg])) == 8'h00)
		else $error("program set a bit");
endmodule // fpec_top

`default_nettype wire

// [pkg/fpec_pkg.sv]
// constants, types and register map of the nvm program/erase controller
// assumes a single 125 MHz clock shared by core, bus and array
package fpec_pkg;
	// ==========================================================
	// timing
	localparam longint unsigned CLK_MHZ       = 125;
	localparam longint unsigned PROG_TIME_NS  = 40000;
	localparam longint unsigned ERASE_TIME_NS = 20000000;
	// least times, rounded up to whole cycles
	localparam int unsigned PROG_CYC  = int'((PROG_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned ERASE_CYC = int'((ERASE_TIME_NS * CLK_MHZ + 999) / 1000);

	// ==========================================================
	// register map (byte addresses)
	localparam logic [11:0] OFS_CONTROL = 12'h000;
	localparam logic [11:0] OFS_KEY     = 12'h004;
	localparam logic [11:0] OFS_STATUS  = 12'h008;
	localparam logic [11:0] OFS_RESET_SOURCE = 12'h00c;
	localparam int unsigned WE_BIT      = 0;
	localparam int unsigned EE_BIT      = 1;
	localparam int unsigned ERRFLAG_BIT = 0;
	localparam logic [1:0]  CONTROL_RST = 2'h0;

	// ==========================================================
	// key codes and array geometry
	localparam logic [7:0]  KEY_FIRST  = 8'ha5;
	localparam logic [7:0]  KEY_SECOND = 8'hf1;
	localparam int unsigned PAGE_BYTES = 512;
	localparam int unsigned PAGE_W     = 9;
	localparam logic [7:0]  ERASED     = 8'hff;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		KS_LOCKED  = 2'h0,
		KS_FIRST   = 2'h1,
		KS_ARMED   = 2'h3,
		KS_BLOCKED = 2'h2
	} fpec_key_state_t;

	typedef struct packed {
		logic        valid;
		logic        short_addr;
		logic [15:0] addr;
		logic [7:0]  data;
	} fpec_move_req_t;

	typedef struct packed {
		logic        valid;
		logic        erase;
		logic [15:0] addr;
		logic [7:0]  data;
	} fpec_dbg_req_t;
endpackage

// [test/fpec_core_model.sv]
// core model: issues move-writes and waits out the stall
// assumes the controller's pclk domain
`timescale 1ns/1ps
`default_nettype none
module fpec_core_model (
	// clock
	input  wire logic                    pclk,
	// controller side
	input  wire logic                    core_stall,
	output var  fpec_pkg::fpec_move_req_t move_req
);
	initial move_req = '0;

	// =======
	// move-write, counts stalled cycles
	task automatic move(input logic s, input logic [15:0] a, input logic [7:0] d,
			output int n);
		int i;
		n = 0;
		@(posedge pclk);
		move_req <= '{1'b1, s, a, d};
		@(posedge pclk);
		// released fields flip so a stale value is never read
		move_req <= '{1'b0, ~s, ~a, ~d};
		for (i = 0; i < 2000; i++) begin
			@(posedge pclk);
			if (core_stall === 1'b1)
				n++;
			else if (n > 0 || i > 3)
				break;
		end
	endtask
endmodule // fpec_core_model
`default_nettype wire

// [test/flash_program_erase_control_tb.sv]
// bench for the nvm program/erase controller
// assumes fpec_core_model as the core issuing move-writes
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_tb;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] r;
		logic        e;
	} fpec_row_t;
	localparam int unsigned PC = 4;
	localparam int unsigned EC = 520;
	localparam logic [11:0] CT = fpec_pkg::OFS_CONTROL;
	localparam logic [11:0] KY = fpec_pkg::OFS_KEY;
	localparam logic [11:0] ST = fpec_pkg::OFS_STATUS;
	localparam logic [11:0] RS = fpec_pkg::OFS_RESET_SOURCE;
	logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, er;
	logic core_stall, ram_wr_valid, vmon_enable, vmon_reset_enable, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] code_addr;
	logic [7:0]  code_data, ram_wr_data, ram_d;
	logic [15:0] ram_wr_addr, ram_a;
	fpec_pkg::fpec_move_req_t move_req;
	fpec_pkg::fpec_dbg_req_t  dbg_req;
	int fails, checked, ram_n, err_n, n, i;
	fpec_row_t rows[7];

	fpec_top #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) DUT (.pclk(pclk), .presetn(presetn),
		.por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.move_req(move_req), .code_addr(code_addr), .code_data(code_data),
		.core_stall(core_stall), .ram_wr_valid(ram_wr_valid), .ram_wr_addr(ram_wr_addr),
		.ram_wr_data(ram_wr_data), .dbg_req(dbg_req), .vmon_enable(vmon_enable),
		.vmon_reset_enable(vmon_reset_enable), .nvm_error_device_reset(err));
	fpec_core_model core (.pclk(pclk), .core_stall(core_stall), .move_req(move_req));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (ram_wr_valid === 1'b1) begin
			ram_n++;
			ram_a = ram_wr_addr;
			ram_d = ram_wr_data;
		end
		if (err === 1'b1)
			err_n++;
	end

	// =======
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic results();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (k == 20) begin
			fails++;
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic keys(input logic [7:0] k1, input logic [7:0] k2, input int gap);
		apb(1'b1, KY, {24'h0, k1});
		repeat (gap) @(posedge pclk);
		apb(1'b1, KY, {24'h0, k2});
	endtask
	task automatic ks(input logic [1:0] x);
		apb(1'b0, KY, 32'h0);
		chk(rd, {30'h0, x});
	endtask
	task automatic code(input logic [13:0] a, input logic [7:0] x);
		@(posedge pclk);
		code_addr <= a;
		repeat (2) @(posedge pclk);
		chk({24'h0, code_data}, {24'h0, x});
	endtask
	task automatic dbg(input logic e, input logic [15:0] a, input logic [7:0] d, input int w);
		@(posedge pclk);
		dbg_req <= '{1'b1, e, a, d};
		@(posedge pclk);
		dbg_req <= '{1'b0, ~e, ~a, ~d};
		@(posedge pclk);
		chk({31'h0, core_stall}, 32'h1);
		repeat (w) @(posedge pclk);
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask

	// =======
	// hang guard
	initial begin
		repeat (50000) @(posedge pclk);
		fails++;
		results();
	end

	// =======
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, code_addr} = '0;
		{dbg_req, presetn, por_n, fails, checked, ram_n, err_n} = '0;
		vmon_enable = 1'b1;
		vmon_reset_enable = 1'b1;
		rows[0] = '{1'b1, CT, 32'h3, 32'h0, 1'b0};
		rows[1] = '{1'b0, CT, 32'h0, 32'h3, 1'b0};
		rows[2] = '{1'b1, KY, 32'ha5, 32'h0, 1'b0};
		rows[3] = '{1'b0, ST, 32'h0, 32'h11, 1'b0};
		rows[4] = '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1};
		rows[5] = '{1'b1, 12'h014, 32'h1, 32'h0, 1'b1};
		rows[6] = '{1'b0, KY, 32'h0, 32'h1, 1'b0};
		rst();
		chk({31'h0, core_stall}, 32'h0);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk({31'h0, er}, {31'h0, rows[i].e});
			if (!rows[i].w)
				chk(rd, rows[i].r);
		end
		$display("register test done");
		rst();
		for (i = 0; i < 2; i++) begin
			apb(1'b1, CT, 32'h3);
			keys(8'ha5, 8'hf1, 20);
			core.move(1'b0, 16'(i * 512 + 'h34), 8'h00, n);
			chk(n, EC);
			ks(2'h0);
			apb(1'b0, CT, 32'h0);
			chk(rd, 32'h3);
			code(14'(i * 512), 8'hff);
			code(14'(i * 512 + 511), 8'hff);
		end
		$display("erase test done");
		apb(1'b1, CT, 32'h1);
		code(14'h0210, 8'hff);
		keys(8'ha5, 8'hf1, 0);
		core.move(1'b0, 16'h0210, 8'h3c, n);
		chk(n, PC);
		code(14'h0210, 8'h3c);
		code(14'h0211, 8'hff);
		keys(8'ha5, 8'hf1, 0);
		core.move(1'b0, 16'h0210, 8'hf0, n);
		chk(n, PC);
		code(14'h0210, 8'h30);
		keys(8'ha5, 8'hf1, 0);
		core.move(1'b1, 16'h0233, 8'h12, n);
		chk(n, PC);
		code(14'h0033, 8'h12);
		code(14'h0233, 8'hff);
		dbg(1'b0, 16'h0220, 8'h5a, PC + 4);
		code(14'h0220, 8'h5a);
		ks(2'h0);
		dbg(1'b1, 16'h0040, 8'h00, EC + 4);
		code(14'h0033, 8'hff);
		$display("program test done");
		apb(1'b1, CT, 32'h0);
		core.move(1'b0, 16'h1234, 8'h77, n);
		chk(n, 0);
		chk(ram_n, 1);
		chk({ram_a, 8'h0, ram_d}, 32'h1234_0077);
		ks(2'h0);
		for (i = 0; i < 2; i++) begin
			apb(1'b1, CT, 32'h1);
			keys(8'ha5, 8'hf1, 0);
			vmon_enable <= i[0];
			vmon_reset_enable <= ~i[0];
			repeat (4) @(posedge pclk);
			core.move(1'b0, 16'h0240, 8'h00, n);
			chk(n, 0);
			chk(err_n, i + 1);
			vmon_enable <= 1'b1;
			vmon_reset_enable <= 1'b1;
			rst();
			apb(1'b0, RS, 32'h0);
			chk({31'h0, rd[0]}, 32'h1);
			apb(1'b1, RS, 32'h1);
		end
		apb(1'b0, RS, 32'h0);
		chk(rd, 32'h0);
		code(14'h0240, 8'hff);
		$display("supply test done");
		keys(8'ha5, 8'ha5, 3);
		ks(2'h2);
		keys(8'ha5, 8'hf1, 0);
		ks(2'h2);
		apb(1'b1, CT, 32'h1);
		core.move(1'b0, 16'h0250, 8'h00, n);
		chk(n, 0);
		rst();
		apb(1'b1, CT, 32'h1);
		core.move(1'b0, 16'h0250, 8'h00, n);
		chk(n, 0);
		ks(2'h2);
		rst();
		keys(8'hf1, 8'ha5, 0);
		ks(2'h2);
		code(14'h0250, 8'hff);
		$display("lock test done");
		results();
	end
endmodule // flash_program_erase_control_tb
`default_nettype wire
